// file: otam_pkg.sv
// shared constants and types of the overheat timer and alert mask block
// assumes a 40 MHz core clock and a register port driven by on-chip serial bus logic
package otam_pkg;

  // register offsets
  localparam logic [7:0] OTAM_ADDR_STATUS_FIRST  = 8'h41;
  localparam logic [7:0] OTAM_ADDR_STATUS_SECOND = 8'h42;
  localparam logic [7:0] OTAM_ADDR_MASK_FIRST    = 8'h74;
  localparam logic [7:0] OTAM_ADDR_MASK_SECOND   = 8'h75;
  localparam logic [7:0] OTAM_ADDR_CONFIG_THREE  = 8'h78;
  localparam logic [7:0] OTAM_ADDR_TIMER_VALUE   = 8'h79;
  localparam logic [7:0] OTAM_ADDR_TIMER_LIMIT   = 8'h7a;
  localparam logic [7:0] OTAM_ADDR_CONFIG_FOUR   = 8'h7d;

  // values after reset
  localparam logic [7:0] OTAM_RST_MASK   = 8'h00;
  localparam logic [7:0] OTAM_RST_CONFIG = 8'h00;
  localparam logic [7:0] OTAM_RST_LIMIT  = 8'h00;
  localparam logic [7:0] OTAM_RST_STATUS = 8'h00;

  // configuration register three fields
  localparam int OTAM_CFG3_ALERT_EN   = 0;
  localparam int OTAM_CFG3_OVH_EN     = 1;
  localparam int OTAM_CFG3_FULL_SPEED = 2;

  // first status register: used source positions, bit 7 summarises the second
  localparam int         OTAM_ST1_ANY_SECOND = 7;
  localparam logic [7:0] OTAM_ST1_USED       = 8'hf6;
  localparam logic [7:0] OTAM_ST2_USED       = 8'hfe;
  localparam int         OTAM_ST2_FAN_FOUR   = 5;

  // timer: one count is 22.76 ms; value saturates at full scale
  localparam int         OTAM_CLK_PERIOD_PS = 25000;
  localparam longint     OTAM_TICK_PS       = 64'd22760000000;
  localparam int         OTAM_TICK_CYCLES   = int'(OTAM_TICK_PS / OTAM_CLK_PERIOD_PS);
  localparam logic [7:0] OTAM_TIMER_FULL    = 8'hff;

  typedef enum logic [1:0] {
    OTAM_PIN9_SPEED    = 2'b00,
    OTAM_PIN9_OVERHEAT = 2'b01,
    OTAM_PIN9_ALERT    = 2'b10,
    OTAM_PIN9_GPIO     = 2'b11
  } otam_pin9_t;

  // register request from the serial bus logic
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } otam_reg_req_t;

  // live out-of-limit conditions from the measurement logic
  typedef struct packed {
    logic remote_two_temp;
    logic local_temp;
    logic remote_one_temp;
    logic main_supply_channel;
    logic processor_supply_channel;
    logic diode_two_fault;
    logic diode_one_fault;
    logic fourth_fan_fail;
    logic third_fan_fail;
    logic second_fan_fail;
    logic first_fan_fail;
    logic critical_overheat;
  } otam_cond_t;

endpackage

// file: otam_sync.sv
// two flip-flop synchroniser for pin levels
// assumes the input is asynchronous to clk; only the second stage is read
`timescale 1ns/1ps
module otam_sync
  import otam_pkg::*;
#(
  parameter int         W         = 1,
  parameter logic [0:0] RST_LEVEL = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } otam_sync_st_t;

  otam_sync_st_t s_r;
  otam_sync_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= {(2 * W){RST_LEVEL}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.sync;

endmodule

// file: otam_timer.sv
// cumulative assertion timer with clear-on-read and saturation
// assumes hot is already synchronised and gated by the function enable
`timescale 1ns/1ps
module otam_timer
  import otam_pkg::*;
#(
  parameter int TICK_CYCLES = OTAM_TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       hot,
  input  wire logic       clear,
  output logic      [7:0] value
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0] sub;
    logic [7:0]    units;
    logic          seen;
  } otam_tmr_st_t;

  otam_tmr_st_t s_r;
  otam_tmr_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      // a read mid-assertion restarts at zero but still shows the assertion
      s_nxt.sub   = '0;
      s_nxt.units = 8'h00;
      s_nxt.seen  = hot;
    end else if (hot && s_r.units != OTAM_TIMER_FULL) begin
      s_nxt.seen = 1'b1;
      if (s_r.sub == TW'(TICK_CYCLES - 1)) begin
        s_nxt.sub   = '0;
        s_nxt.units = s_r.units + 8'h01;
      end else begin
        s_nxt.sub = s_r.sub + TW'(1);
      end
    end
    // released or saturated: everything holds
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // below two counts only the first-assertion bit shows
  assign value = (s_r.units >= 8'h02) ? s_r.units : {7'h00, s_r.seen};

endmodule

// file: otam_top.sv
// overheat assertion timer, limit compare, alert masks and pin 5 / pin 9 functions
// assumes REG_REQ and COND come from logic on CLOCK; PIN9_IN comes from the pad
// How it works
// - first mask bits 7,6,5,4,2,0 block alert for their first-status sources
// - second mask bits 7..1 block alert for diode, fan and critical sources
// - in overheat mode second mask bit 5 blocks timer alerts instead of fan four
// - masking blocks only the alert; the timer status bit still sets
// - after reset no pin carries the alert output
// - config three bit 0 makes pin 5 the alert output
// - config four bits 1:0 pick pin 9 as speed, overheat, alert or general pin
// - full-speed bit makes all fans run flat out while overheat input is low
// - full speed applies only if fans already run
// - timer runs while asserted, pauses when released, resumes afterwards
// - timer clears when read and sticks at full scale until then
// - first assertion sets bit 0; past 45.52 ms counts 22.76 ms steps
// - read during assertion restarts at one; limit zero then sets the flag
// - limit register holds threshold, compared continuously with the timer
// - timer above limit sets second status bit 5 and, unmasked, the alert
// - limit zero alerts on first assertion, limit one past 45.52 ms
// - status bits are sticky; a read clears them only once the cause is gone
// - alert stays low through the condition and until the status read
`timescale 1ns/1ps
module otam_top
  import otam_pkg::*;
#(
  parameter int TICK_CYCLES = OTAM_TICK_CYCLES
) (
  input  wire logic          CLOCK,
  input  wire logic          RST_B,
  input  wire otam_reg_req_t REG_REQ,
  output logic         [7:0] REG_RDATA,
  output logic               REG_RVALID,
  input  wire otam_cond_t    COND,
  input  wire logic          FANS_RUNNING,
  output logic               FAN_FULL_SPEED,
  input  wire logic          PIN5_IN,
  output logic               PIN5_OUT,
  output logic               PIN5_OE_B,
  input  wire logic          PIN9_IN,
  output logic               PIN9_OUT,
  output logic               PIN9_OE_B
);

  typedef struct packed {
    logic [7:0] mask_first;
    logic [7:0] mask_second;
    logic [7:0] config_three;
    logic [7:0] config_four;
    logic [7:0] timer_limit;
    logic [7:0] status_first;
    logic [7:0] status_second;
    logic [7:0] rdata;
    logic       rvalid;
    logic       full_speed;
    logic       pin5_oe_b;
    logic       pin9_oe_b;
  } otam_top_st_t;

  otam_top_st_t s_r;
  otam_top_st_t s_nxt;

  logic       pin9_sync;
  logic       ovh_active;
  logic       hot;
  logic       timer_clear;
  logic [7:0] timer_value;
  logic       timer_over;
  logic [7:0] cond_first;
  logic [7:0] cond_second;
  logic [7:0] mask_first_eff;
  logic       alert_second;
  logic       alert;

  // register read mux; clear-on-read below decodes the address on its own
  function automatic logic [7:0] reg_read(input logic [7:0] a, input otam_top_st_t s,
                                          input logic [7:0] tv);
    logic [7:0] d;
    d = 8'h00;
    if (a == OTAM_ADDR_STATUS_FIRST) begin
      d = s.status_first;
    end else if (a == OTAM_ADDR_STATUS_SECOND) begin
      d = s.status_second;
    end else if (a == OTAM_ADDR_MASK_FIRST) begin
      d = s.mask_first;
    end else if (a == OTAM_ADDR_MASK_SECOND) begin
      d = s.mask_second;
    end else if (a == OTAM_ADDR_CONFIG_THREE) begin
      d = s.config_three;
    end else if (a == OTAM_ADDR_TIMER_VALUE) begin
      d = tv;
    end else if (a == OTAM_ADDR_TIMER_LIMIT) begin
      d = s.timer_limit;
    end else if (a == OTAM_ADDR_CONFIG_FOUR) begin
      d = s.config_four;
    end
    return d;
  endfunction

  // sticky update: set wins over a read, a read clears only a departed cause
  function automatic logic [7:0] sticky(input logic [7:0] st, input logic [7:0] cond,
                                        input logic rd, input logic [7:0] used);
    logic [7:0] keep;
    keep = rd ? (st & cond) : st;
    return (keep | cond) & used;
  endfunction

  // pad level is asynchronous; released pin reads high
  otam_sync #(
    .W         (1),
    .RST_LEVEL (1'b1)
  ) u_pin9_sync (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .d     (PIN9_IN),
    .q     (pin9_sync)
  );

  // overheat input needs both the pin 9 select and the enable bit
  assign ovh_active = (otam_pin9_t'(s_r.config_four[1:0]) == OTAM_PIN9_OVERHEAT) &&
                      s_r.config_three[OTAM_CFG3_OVH_EN];
  assign hot = ovh_active && !pin9_sync;

  assign timer_clear = REG_REQ.rd && (REG_REQ.addr == OTAM_ADDR_TIMER_VALUE);

  otam_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .hot   (hot),
    .clear (timer_clear),
    .value (timer_value)
  );

  // continuous strict compare; limit zero trips on the first assertion
  assign timer_over = timer_value > s_r.timer_limit;

  always_comb begin
    cond_first = 8'h00;
    cond_first[6] = COND.remote_two_temp;
    cond_first[5] = COND.local_temp;
    cond_first[4] = COND.remote_one_temp;
    cond_first[2] = COND.main_supply_channel;
    cond_first[1] = COND.processor_supply_channel;
  end

  always_comb begin
    cond_second = 8'h00;
    cond_second[7] = COND.diode_two_fault;
    cond_second[6] = COND.diode_one_fault;
    // fan four failure and timer share one status bit
    cond_second[OTAM_ST2_FAN_FOUR] = ovh_active ? timer_over
                                                : COND.fourth_fan_fail;
    cond_second[4] = COND.third_fan_fail;
    cond_second[3] = COND.second_fan_fail;
    cond_second[2] = COND.first_fan_fail;
    cond_second[1] = COND.critical_overheat;
  end

  // processor supply sits at status bit 1 but its mask at bit 0
  always_comb begin
    mask_first_eff = {s_r.mask_first[7:4], 1'b1, s_r.mask_first[2],
                      s_r.mask_first[0], 1'b1};
  end

  // second-status sources reach the alert through their own mask and the summary mask
  assign alert_second = |(s_r.status_second & ~s_r.mask_second & OTAM_ST2_USED) &&
                        !s_r.mask_first[OTAM_ST1_ANY_SECOND];
  // status bits set regardless of masks; only this OR is gated
  assign alert = |(s_r.status_first[6:0] & ~mask_first_eff[6:0]) || alert_second;

  always_comb begin
    s_nxt = s_r;

    s_nxt.status_second = sticky(s_r.status_second, cond_second,
                                 REG_REQ.rd && (REG_REQ.addr == OTAM_ADDR_STATUS_SECOND),
                                 OTAM_ST2_USED);
    s_nxt.status_first = sticky(s_r.status_first, cond_first,
                                REG_REQ.rd && (REG_REQ.addr == OTAM_ADDR_STATUS_FIRST),
                                OTAM_ST1_USED);
    s_nxt.status_first[OTAM_ST1_ANY_SECOND] = |s_nxt.status_second;

    if (REG_REQ.wr) begin
      if (REG_REQ.addr == OTAM_ADDR_MASK_FIRST) begin
        s_nxt.mask_first = REG_REQ.wdata;
      end else if (REG_REQ.addr == OTAM_ADDR_MASK_SECOND) begin
        s_nxt.mask_second = REG_REQ.wdata;
      end else if (REG_REQ.addr == OTAM_ADDR_CONFIG_THREE) begin
        s_nxt.config_three = REG_REQ.wdata;
      end else if (REG_REQ.addr == OTAM_ADDR_TIMER_LIMIT) begin
        s_nxt.timer_limit = REG_REQ.wdata;
      end else if (REG_REQ.addr == OTAM_ADDR_CONFIG_FOUR) begin
        s_nxt.config_four = REG_REQ.wdata;
      end
    end

    s_nxt.rvalid = REG_REQ.rd;
    s_nxt.rdata  = REG_REQ.rd ? reg_read(REG_REQ.addr, s_r, timer_value) : s_r.rdata;

    // a stopped fan stays stopped: override only lifts running fans
    s_nxt.full_speed = s_r.config_three[OTAM_CFG3_FULL_SPEED] && hot &&
                       FANS_RUNNING;

    // open drain: enable low pulls the line low, high releases it
    s_nxt.pin5_oe_b = !(s_r.config_three[OTAM_CFG3_ALERT_EN] && alert);
    s_nxt.pin9_oe_b = !((otam_pin9_t'(s_r.config_four[1:0]) == OTAM_PIN9_ALERT) &&
                        alert);
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s_r.mask_first    <= OTAM_RST_MASK;
      s_r.mask_second   <= OTAM_RST_MASK;
      s_r.config_three  <= OTAM_RST_CONFIG;
      s_r.config_four   <= OTAM_RST_CONFIG;
      s_r.timer_limit   <= OTAM_RST_LIMIT;
      s_r.status_first  <= OTAM_RST_STATUS;
      s_r.status_second <= OTAM_RST_STATUS;
      s_r.rdata         <= 8'h00;
      s_r.rvalid        <= 1'b0;
      s_r.full_speed    <= 1'b0;
      s_r.pin5_oe_b     <= 1'b1;
      s_r.pin9_oe_b     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pads only ever pull low; PIN5_IN is unused as pin 5 has no input role here
  logic drive_low_r;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      drive_low_r <= 1'b0;
    end else begin
      drive_low_r <= 1'b0;
    end
  end

  assign REG_RDATA      = s_r.rdata;
  assign REG_RVALID     = s_r.rvalid;
  assign FAN_FULL_SPEED = s_r.full_speed;
  assign PIN5_OUT       = drive_low_r;
  assign PIN5_OE_B      = s_r.pin5_oe_b;
  assign PIN9_OUT       = drive_low_r;
  assign PIN9_OE_B      = s_r.pin9_oe_b;

endmodule

// file: otam_monitor.sv
// port checker for otam_top
// assumes one clock domain and a bind to every otam_top instance
`timescale 1ns/1ps
module otam_monitor
  import otam_pkg::*;
(
  input wire logic          CLOCK,
  input wire logic          RST_B,
  input wire otam_reg_req_t REG_REQ,
  input wire logic    [7:0] REG_RDATA,
  input wire logic          REG_RVALID,
  input wire otam_cond_t    COND,
  input wire logic          FANS_RUNNING,
  input wire logic          FAN_FULL_SPEED,
  input wire logic          PIN5_OUT,
  input wire logic          PIN5_OE_B,
  input wire logic          PIN9_IN,
  input wire logic          PIN9_OUT,
  input wire logic          PIN9_OE_B
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  a_reset_no_alert: assert property ($rose(RST_B) |-> PIN5_OE_B && PIN9_OE_B)
    else $error("alert active after reset");
  a_pins_pull_low: assert property (PIN5_OUT == 1'b0 && PIN9_OUT == 1'b0)
    else $error("pin drives high");
  a_full_needs_run: assert property (FAN_FULL_SPEED |-> $past(FANS_RUNNING))
    else $error("full speed with fans stopped");
  a_full_needs_hot: assert property (FAN_FULL_SPEED |-> !$past(PIN9_IN, 3))
    else $error("full speed without overheat");
  // the alert only lets go two cycles after a read or a write
  a_alert_hold: assert property ($rose(PIN5_OE_B) |-> $past(REG_REQ.rd || REG_REQ.wr, 2))
    else $error("alert released without access");
  a_alert_cause: assert property ($fell(PIN5_OE_B) |->
    $past(|COND || REG_REQ.wr, 2) || !$past(PIN9_IN, 5))
    else $error("alert without cause");
  a_read_answer: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered");
  a_no_spurious: assert property (REG_RVALID |-> $past(REG_REQ.rd))
    else $error("answer without read");
  a_rdata_holds: assert property (!REG_RVALID |-> $stable(REG_RDATA))
    else $error("read data moved");
endmodule
bind otam_top otam_monitor otam_monitor_inst (.CLOCK, .RST_B, .REG_REQ, .REG_RDATA,
  .REG_RVALID, .COND, .FANS_RUNNING, .FAN_FULL_SPEED, .PIN5_OUT, .PIN5_OE_B, .PIN9_IN,
  .PIN9_OUT, .PIN9_OE_B);

// file: otam_hot_model.sv
// overheat source on pin 9 with the board pull-up
// assumes hot_req comes from the bench on the rising clock edge
`timescale 1ns/1ps
module otam_hot_model (
  input  wire logic hot_req,
  input  wire logic oe_b,
  output logic      pin
);
  // open drain: wire is low while either side pulls, else the pull-up wins
  always_comb begin
    pin = !hot_req && oe_b;
  end
endmodule

// file: tb_top.sv
// bench for otam_top: register access, status, alert pins and overheat timer
// assumes TICK_CYCLES of 8 so that timer counts stay short
`timescale 1ns/1ps
module tb_top
  import otam_pkg::*;
;
  localparam int T = 8;
  logic          clock = 1'b0;
  logic          rst_b = 1'b0;
  otam_reg_req_t req = '0;
  otam_cond_t    cond = '0;
  logic          fans = 1'b0;
  logic          hot_req = 1'b0;
  logic    [7:0] rdata;
  logic    [7:0] got;
  logic    [7:0] mb;
  logic          rvalid, full, p5o, p5oe, p9o, p9oe, pin9, mk;
  int            err_total = 0;
  int            n_tests = 0;
  int            seed = 1856;
  int            n, lim, i, k;
  int            mp [5] = '{0, 2, 4, 5, 6};
  logic    [7:0] adr [9] = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7a, 8'h7d, 8'h50};
  always #12.5 clock = ~clock;
  otam_top #(.TICK_CYCLES(T)) otam_top_inst (.CLOCK(clock), .RST_B(rst_b), .REG_REQ(req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .COND(cond), .FANS_RUNNING(fans),
    .FAN_FULL_SPEED(full), .PIN5_IN(1'b1), .PIN5_OUT(p5o), .PIN5_OE_B(p5oe),
    .PIN9_IN(pin9), .PIN9_OUT(p9o), .PIN9_OE_B(p9oe));
  otam_hot_model otam_hot_model_inst (.hot_req(hot_req), .oe_b(p9oe), .pin(pin9));
  // timer model: one for a short assertion, then whole counts, stuck at full scale
  function automatic logic [7:0] tv(input int c);
    if (c == 0) return 8'h00;
    if (c < 2 * T) return 8'h01;
    return (c / T > 255) ? 8'hff : 8'(c / T);
  endfunction
  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int w;
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
    w = 0;
    #1;
    while (rvalid !== 1'b1 && w < 4) begin
      @(posedge clock);
      #1;
      w++;
    end
    if (rvalid !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, got);
    chk($sformatf("reg %h", a), got, e);
  endtask
  task automatic pulse(input int b);
    @(posedge clock);
    cond <= otam_cond_t'(12'h001 << b);
    @(posedge clock);
    cond <= '0;
    cyc(3);
    #1;
  endtask
  // pin 9 low for len sampled edges; fans state drawn at random per assertion
  task automatic hot(input int len);
    @(posedge clock);
    hot_req <= 1'b1;
    fans <= 1'($random(seed));
    cyc(len);
    #1;
    if (len > 3) chk("full speed", {7'h00, full}, {7'h00, fans});
    hot_req <= 1'b0;
    n += len;
  endtask
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rc(adr[i], 8'h00);
    end
    for (i = 2; i < 5; i++) begin
      mb = 8'($random(seed));
      wr(adr[i == 4 ? 6 : i], mb);
      rc(adr[i == 4 ? 6 : i], mb);
    end
    wr(8'h79, 8'hff);
    rc(8'h79, 8'h00);
    $display("test registers done");
    wr(8'h78, 8'h01);
    @(posedge clock);
    cond <= '{first_fan_fail: 1'b1, default: 1'b0};
    rc(8'h42, 8'h04);
    rc(8'h42, 8'h04);
    cond <= '0;
    rc(8'h42, 8'h04);
    rc(8'h42, 8'h00);
    rd(8'h41, got);
    for (i = 0; i < 24; i++) begin
      k = i % 12;
      mb = (k < 7) ? 8'h02 << k : 8'h01 << mp[k - 7];
      wr(8'h74, (i > 11 && k > 6) ? mb : (i == 12) ? 8'h80 : 8'h00);
      wr(8'h75, (i > 12 && k < 7) ? mb : 8'h00);
      pulse(k);
      chk("alert", {7'h00, p5oe}, {7'h00, i > 11});
      rc(8'h41, (k < 7) ? 8'h80 : (k == 7) ? 8'h02 : mb);
      rc(8'h42, (k < 7) ? mb : 8'h00);
      rc(8'h41, 8'h00);
      cyc(3);
      #1;
      chk("alert", {7'h00, p5oe}, 8'h01);
    end
    $display("test masks done");
    wr(8'h78, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'h7d, i[7:0]);
      pulse(1);
      chk("pin9", {7'h00, p9oe}, {7'h00, i != 2});
      chk("alert", {7'h00, p5oe}, 8'h01);
      rd(8'h42, got);
      rd(8'h41, got);
    end
    $display("test pin functions done");
    wr(8'h7d, 8'h01);
    wr(8'h78, 8'h07);
    wr(8'h74, 8'h00);
    for (i = 0; i < 6; i++) begin
      lim = (i < 2) ? i : {$random(seed)} % 8;
      mk = 1'($random(seed));
      wr(8'h7a, lim[7:0]);
      wr(8'h75, {2'b00, mk, 5'h00});
      n = 0;
      repeat (3) hot(1 + {$random(seed)} % 30);
      cyc(6);
      #1;
      chk("alert", {7'h00, p5oe}, {7'h00, !(tv(n) > lim && !mk)});
      rc(8'h79, tv(n));
      rc(8'h42, (tv(n) > lim) ? 8'h20 : 8'h00);
      rc(8'h42, 8'h00);
      rd(8'h41, got);
      cyc(3);
    end
    n = 0;
    hot(2100);
    cyc(6);
    rc(8'h79, tv(n));
    rc(8'h79, 8'h00);
    rd(8'h42, got);
    $display("test timer done");
    wr(8'h7a, 8'h00);
    @(posedge clock);
    hot_req <= 1'b1;
    cyc(10);
    rd(8'h79, got);
    cyc(2);
    rc(8'h79, 8'h01);
    rc(8'h42, 8'h20);
    hot_req <= 1'b0;
    $display("test read in assertion done");
    wrap_up();
  end
endmodule
